// ### common/dock_pkg.sv
// shared constants, types and decoders for the dual oscillator clock control
// ==========================================================================
package dock_pkg;

    // ==========================================================
    // bus and register map
    localparam int          AXI_AW      = 32;
    localparam int          AXI_DW      = 32;
    localparam int          AXI_SW      = AXI_DW / 8;
    localparam logic [31:0] OFS_SLOW    = 32'h0000_0000;
    localparam logic [31:0] OFS_FAST    = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS  = 32'h0000_0008;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 25;
    localparam int STARTUP_DLY_NS = 100;
    localparam int STARTUP_CYC    = (STARTUP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DLY_W          = 3;

    // ==========================================================
    // divider sizing
    localparam int               DIV_W    = 7;
    localparam int               CNT_W    = 6;
    localparam logic [DIV_W-1:0] DIV_ONE  = 7'h01;
    localparam logic [2:0]       FAST_BAD = 3'h7;

    // ==========================================================
    // register layouts, reserved bits read as zero
    typedef struct packed {
        logic [17:0] rsv;
        logic        tap_b_gate;
        logic [2:0]  tap_b_div;
        logic        tap_a_gate;
        logic [2:0]  tap_a_div;
        logic [1:0]  first_div;
        logic        rate;
        logic        ext_sel;
        logic        force_pol;
        logic        always_on;
    } dock_slow_cfg_t;

    typedef struct packed {
        logic [20:0] rsv;
        logic        startup_dly;
        logic [2:0]  tap_div;
        logic [2:0]  first_div;
        logic        tap_gate;
        logic        ext_sel;
        logic        force_pol;
        logic        always_on;
    } dock_fast_cfg_t;

    typedef struct packed {
        logic [24:0] rsv;
        logic        tap_48;
        logic        tap_47;
        logic        tap_46;
        logic        fast_logic;
        logic        slow_logic;
        logic        fast_run;
        logic        slow_run;
    } dock_status_t;

    // ==========================================================
    // ratio decoders
    function automatic logic [DIV_W-1:0] slow_first_ratio(input logic [1:0] code);
        case (code)
            2'h0:    slow_first_ratio = 7'h01;
            2'h1:    slow_first_ratio = 7'h02;
            2'h2:    slow_first_ratio = 7'h04;
            default: slow_first_ratio = 7'h08;
        endcase
    endfunction

    // 111b is refused at write time, so the default never shows
    function automatic logic [DIV_W-1:0] fast_first_ratio(input logic [2:0] code);
        case (code)
            3'h0:    fast_first_ratio = 7'h01;
            3'h1:    fast_first_ratio = 7'h02;
            3'h2:    fast_first_ratio = 7'h04;
            3'h3:    fast_first_ratio = 7'h08;
            3'h4:    fast_first_ratio = 7'h0C;
            3'h5:    fast_first_ratio = 7'h18;
            3'h6:    fast_first_ratio = 7'h30;
            default: fast_first_ratio = 7'h01;
        endcase
    endfunction

    // fast flag swaps the /3 and /4 codes
    function automatic logic [DIV_W-1:0] tap_ratio(input logic [2:0] code, input logic fast);
        case (code)
            3'h0:    tap_ratio = 7'h01;
            3'h1:    tap_ratio = 7'h02;
            3'h2:    tap_ratio = fast ? 7'h04 : 7'h03;
            3'h3:    tap_ratio = fast ? 7'h03 : 7'h04;
            3'h4:    tap_ratio = 7'h08;
            3'h5:    tap_ratio = 7'h0C;
            3'h6:    tap_ratio = 7'h18;
            default: tap_ratio = 7'h40;
        endcase
    endfunction

    // byte-lane merge for register writes
    function automatic logic [AXI_DW-1:0] lane_merge(input logic [AXI_DW-1:0] old_v,
                                                     input logic [AXI_DW-1:0] new_v,
                                                     input logic [AXI_SW-1:0] strb);
        logic [AXI_DW-1:0] r;
        r = old_v;
        for (int i = 0; i < AXI_SW; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction

endpackage

// ### design/dock_div.sv
// edge counting clock divider with clean clear and gated output
module dock_div
    import dock_pkg::*;
(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             clk_in,
    input  wire logic             clear,
    input  wire logic [DIV_W-1:0] ratio,
    output logic                  clk_out
);

    typedef struct packed {
        logic             prev;
        logic [CNT_W-1:0] pos;
        logic             out;
    } dock_div_state_t;

    dock_div_state_t st_ff;
    dock_div_state_t nxt_st;

    // ==========================================================
    // next state: count rising edges, high for the first half
    always_comb begin
        logic rise;
        rise = clk_in & ~st_ff.prev;
        nxt_st = st_ff;
        nxt_st.prev = clk_in;
        if (clear) begin
            // parked low with the phase at zero: no runt after release
            nxt_st.pos = '0;
            nxt_st.out = 1'b0;
        end else if (ratio == DIV_ONE) begin
            // pass-through only rises on a real edge
            nxt_st.out = rise | (st_ff.out & clk_in);
        end else if (rise) begin
            nxt_st.out = (st_ff.pos < CNT_W'(ratio >> 1));
            if (st_ff.pos == CNT_W'(ratio - DIV_ONE)) begin
                nxt_st.pos = '0;
            end else begin
                nxt_st.pos = st_ff.pos + CNT_W'(DIV_ONE);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign clk_out = st_ff.out;

endmodule

// ### design/dock_top.sv
// dual oscillator clock control with enable logic, dividers and register slave
//
// The address map and register access over AXI4-Lite were left to the implementer.
module dock_top
    import dock_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite slave
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_DW-1:0] s_axi_wdata,
    input  wire logic [AXI_SW-1:0] s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [AXI_DW-1:0]      s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // device level inputs
    input  wire logic              power_on_ok,
    input  wire logic              trim_enable,
    input  wire logic              slow_matrix_force,
    input  wire logic              fast_matrix_force,
    input  wire logic              slow_cell_request,
    input  wire logic              fast_cell_request,
    input  wire logic              comparator_request,
    // raw oscillator and pin clocks
    input  wire logic              low_frequency_source,
    input  wire logic              ring_source,
    input  wire logic              general_pin_zero,
    input  wire logic              general_pin_one,
    // controls toward the oscillator circuits
    output logic                   slow_osc_run,
    output logic                   fast_osc_run,
    output logic                   slow_osc_rate_select,
    // clock taps toward the connection matrix
    output logic                   matrix_input_46,
    output logic                   matrix_input_47,
    output logic                   matrix_input_48
);

    // ==========================================================
    // input synchroniser lanes
    localparam int NUM_IN    = 11;
    localparam int I_POR     = 0;
    localparam int I_TRIM    = 1;
    localparam int I_FORCE0  = 2;
    localparam int I_FORCE1  = 3;
    localparam int I_REQ0    = 4;
    localparam int I_REQ1    = 5;
    localparam int I_COMP    = 6;
    localparam int I_SRC0    = 7;
    localparam int I_SRC1    = 8;
    localparam int I_PIN0    = 9;
    localparam int I_PIN1    = 10;

    typedef struct packed {
        logic [NUM_IN-1:0] s1;
        logic [NUM_IN-1:0] s2;
        logic [NUM_IN-1:0] s3;
        logic [NUM_IN-1:0] filt;
        dock_slow_cfg_t    slow;
        dock_fast_cfg_t    fast;
        logic              slow_run;
        logic              fast_run;
        logic [DLY_W-1:0]  dly;
        logic              aw_have;
        logic              w_have;
        logic [AXI_AW-1:0] awaddr;
        logic [AXI_DW-1:0] wdata;
        logic [AXI_SW-1:0] wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [AXI_DW-1:0] rdata;
        logic [1:0]        rresp;
    } dock_state_t;

    dock_state_t       st_ff;
    dock_state_t       nxt_st;
    logic [NUM_IN-1:0] raw_in;
    logic              slow_logic;
    logic              fast_logic;
    logic              slow_want;
    logic              fast_want;
    logic              slow_active;
    logic              fast_active;
    logic              slow_src;
    logic              fast_src;
    logic              slow_first;
    logic              fast_first;
    logic              tap_46;
    logic              tap_47;
    logic              tap_48;
    dock_status_t      status;

    // ==========================================================
    // oscillator enable ranking, shared by both oscillators
    function automatic logic osc_enable(input logic por,
                                        input logic trim,
                                        input logic ext_sel,
                                        input logic force_hi,
                                        input logic force_pol,
                                        input logic always_on,
                                        input logic request);
        if (!por) begin
            osc_enable = 1'b0;
        end else if (trim) begin
            osc_enable = 1'b1;
        end else if (ext_sel) begin
            osc_enable = 1'b0;
        end else if (force_hi) begin
            osc_enable = force_pol;
        end else if (always_on) begin
            osc_enable = 1'b1;
        end else begin
            osc_enable = request;
        end
    endfunction

    // ==========================================================
    // raw lanes, all of them asynchronous to aclk
    always_comb begin
        raw_in         = '0;
        raw_in[I_POR]    = power_on_ok;
        raw_in[I_TRIM]   = trim_enable;
        raw_in[I_FORCE0] = slow_matrix_force;
        raw_in[I_FORCE1] = fast_matrix_force;
        raw_in[I_REQ0]   = slow_cell_request;
        raw_in[I_REQ1]   = fast_cell_request;
        raw_in[I_COMP]   = comparator_request;
        raw_in[I_SRC0]   = low_frequency_source;
        raw_in[I_SRC1]   = ring_source;
        raw_in[I_PIN0]   = general_pin_zero;
        raw_in[I_PIN1]   = general_pin_one;
    end

    // ==========================================================
    // enables and clock source selection from the filtered lanes
    always_comb begin
        // external clock keeps the downstream logic alive
        slow_logic = st_ff.filt[I_POR] & ~st_ff.filt[I_TRIM] & st_ff.slow.ext_sel;
        fast_logic = st_ff.filt[I_POR] & ~st_ff.filt[I_TRIM] & st_ff.fast.ext_sel;
        slow_want  = osc_enable(st_ff.filt[I_POR], st_ff.filt[I_TRIM], st_ff.slow.ext_sel,
                                st_ff.filt[I_FORCE0], st_ff.slow.force_pol, st_ff.slow.always_on,
                                st_ff.filt[I_REQ0] | st_ff.filt[I_COMP]);
        fast_want  = osc_enable(st_ff.filt[I_POR], st_ff.filt[I_TRIM], st_ff.fast.ext_sel,
                                st_ff.filt[I_FORCE1], st_ff.fast.force_pol, st_ff.fast.always_on,
                                st_ff.filt[I_REQ1]);
        slow_active = st_ff.slow_run | slow_logic;
        fast_active = st_ff.fast_run | fast_logic;
        // a stopped oscillator's stray level never reaches the dividers
        slow_src = slow_logic ? st_ff.filt[I_PIN0] : (st_ff.slow_run & st_ff.filt[I_SRC0]);
        fast_src = fast_logic ? st_ff.filt[I_PIN1] : (st_ff.fast_run & st_ff.filt[I_SRC1]);
    end

    // ==========================================================
    // status word as software sees it
    always_comb begin
        status            = '0;
        status.slow_run   = st_ff.slow_run;
        status.fast_run   = st_ff.fast_run;
        status.slow_logic = slow_logic;
        status.fast_logic = fast_logic;
        status.tap_46     = tap_46;
        status.tap_47     = tap_47;
        status.tap_48     = tap_48;
    end

    // ==========================================================
    // next state: synchroniser, run control, register slave
    always_comb begin
        logic [AXI_DW-1:0] merged;
        dock_slow_cfg_t    new_slow;
        dock_fast_cfg_t    new_fast;
        merged   = '0;
        new_slow = '0;
        new_fast = '0;
        nxt_st   = st_ff;

        // three stages; a lane moves once stages two and three agree
        nxt_st.s1   = raw_in;
        nxt_st.s2   = st_ff.s1;
        nxt_st.s3   = st_ff.s2;
        nxt_st.filt = (~(st_ff.s2 ^ st_ff.s3) & st_ff.s3) | ((st_ff.s2 ^ st_ff.s3) & st_ff.filt);

        // slow oscillator follows its enable directly
        nxt_st.slow_run = slow_want;

        // fast oscillator optionally waits out the startup delay
        if (!fast_want) begin
            nxt_st.fast_run = 1'b0;
            nxt_st.dly      = '0;
        end else if (!st_ff.fast.startup_dly) begin
            nxt_st.fast_run = 1'b1;
        end else if (st_ff.dly == DLY_W'(STARTUP_CYC)) begin
            nxt_st.fast_run = 1'b1;
        end else if (!st_ff.fast_run) begin
            nxt_st.dly = st_ff.dly + DLY_W'(DIV_ONE);
        end

        // write address and data, taken in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // commit once both halves are held and no response is pending
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = RESP_OKAY;
            case (st_ff.awaddr)
                OFS_SLOW: begin
                    merged       = lane_merge(st_ff.slow, st_ff.wdata, st_ff.wstrb);
                    new_slow     = dock_slow_cfg_t'(merged);
                    new_slow.rsv = '0;
                    nxt_st.slow  = new_slow;
                end
                OFS_FAST: begin
                    merged       = lane_merge(st_ff.fast, st_ff.wdata, st_ff.wstrb);
                    new_fast     = dock_fast_cfg_t'(merged);
                    new_fast.rsv = '0;
                    // the invalid first divider code is refused, old value kept
                    if (new_fast.first_div == FAST_BAD) begin
                        new_fast.first_div = st_ff.fast.first_div;
                    end
                    nxt_st.fast  = new_fast;
                end
                OFS_STATUS: begin
                    nxt_st.bresp = RESP_OKAY;   // read-only, write dropped
                end
                default: begin
                    nxt_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_st.awready = ~nxt_st.aw_have & ~nxt_st.bvalid;
        nxt_st.wready  = ~nxt_st.w_have & ~nxt_st.bvalid;

        // reads answer one cycle after the address is taken
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = RESP_OKAY;
            case (s_axi_araddr)
                OFS_SLOW:   nxt_st.rdata = st_ff.slow;
                OFS_FAST:   nxt_st.rdata = st_ff.fast;
                OFS_STATUS: nxt_st.rdata = status;
                default: begin
                    nxt_st.rdata = '0;
                    nxt_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        nxt_st.arready = ~nxt_st.rvalid;
    end

    // ==========================================================
    // state register; readies come up one edge after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // first stage dividers, parked while neither their oscillator nor the external clock is in use
    dock_div u_slow_first (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_in  (slow_src),
        .clear   (~slow_active),
        .ratio   (slow_first_ratio(st_ff.slow.first_div)),
        .clk_out (slow_first)
    );

    dock_div u_fast_first (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_in  (fast_src),
        .clear   (~fast_active),
        .ratio   (fast_first_ratio(st_ff.fast.first_div)),
        .clk_out (fast_first)
    );

    // ==========================================================
    // second stage taps; a cleared gate holds the tap low
    dock_div u_tap_46 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_in  (slow_first),
        .clear   (~(slow_active & st_ff.slow.tap_a_gate)),
        .ratio   (tap_ratio(st_ff.slow.tap_a_div, 1'b0)),
        .clk_out (tap_46)
    );

    dock_div u_tap_47 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_in  (slow_first),
        .clear   (~(slow_active & st_ff.slow.tap_b_gate)),
        .ratio   (tap_ratio(st_ff.slow.tap_b_div, 1'b0)),
        .clk_out (tap_47)
    );

    dock_div u_tap_48 (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clk_in  (fast_first),
        .clear   (~(fast_active & st_ff.fast.tap_gate)),
        .ratio   (tap_ratio(st_ff.fast.tap_div, 1'b1)),
        .clk_out (tap_48)
    );

    // ==========================================================
    // outputs, every one straight from a flop
    assign s_axi_awready        = st_ff.awready;
    assign s_axi_wready         = st_ff.wready;
    assign s_axi_bvalid         = st_ff.bvalid;
    assign s_axi_bresp          = st_ff.bresp;
    assign s_axi_arready        = st_ff.arready;
    assign s_axi_rvalid         = st_ff.rvalid;
    assign s_axi_rdata          = st_ff.rdata;
    assign s_axi_rresp          = st_ff.rresp;
    assign slow_osc_run         = st_ff.slow_run;
    assign fast_osc_run         = st_ff.fast_run;
    assign slow_osc_rate_select = st_ff.slow.rate;   // 0 gives 2.048 kHz, 1 gives 10 kHz
    assign matrix_input_46      = tap_46;
    assign matrix_input_47      = tap_47;
    assign matrix_input_48      = tap_48;

endmodule

// ### bench/dock_assertions.sv
// port-level checks for the clock control block
// ====
module dock_assertions (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        power_on_ok,
    input wire logic        trim_enable,
    input wire logic        slow_osc_run,
    input wire logic        fast_osc_run,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // eight quiet cycles cover the input filter plus the run register
    property p_por_off; (!power_on_ok) [*8] |-> !slow_osc_run && !fast_osc_run; endproperty
    a_por_off: assert property (p_por_off) else $error("run without power");
    property p_trim_on; (power_on_ok && trim_enable) [*8] |-> slow_osc_run ##[0:6] fast_osc_run; endproperty
    a_trim_on: assert property (p_trim_on) else $error("trim did not start");
    // bus handshake obligations of the slave
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_b_done: assert property (p_b_done) else $error("bvalid repeated");
    property p_b_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
    a_b_busy: assert property (p_b_busy) else $error("awready during response");
    property p_r_soon; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_soon: assert property (p_r_soon) else $error("read answer late");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data moved");
    property p_r_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_busy: assert property (p_r_busy) else $error("arready during read");
endmodule

// ### bench/dock_partner.sv
// oscillator circuits: output toggles only while enabled
module dock_partner (
    input wire logic aclk,
    input wire logic slow_osc_run,
    input wire logic fast_osc_run,
    output logic     low_frequency_source,
    output logic     ring_source
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] slow_ph, fast_ph;
    // a stopped circuit rests low; period is eight bus clocks
    always_ff @(posedge aclk) begin
        slow_ph <= slow_osc_run ? slow_ph + 3'h1 : 3'h0;
        fast_ph <= fast_osc_run ? fast_ph + 3'h1 : 3'h0;
    end
    assign low_frequency_source = slow_ph[2];
    assign ring_source = fast_ph[2];
endmodule

// ### bench/tb_dock_top.sv
// self-checking testbench for the clock control block
module tb_dock_top import dock_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    // ====
    // signals; protection, strobes and pin clocks are tied
    logic aclk = '0, aresetn = '0, power_on_ok = '0, trim_enable = '0, slow_matrix_force = '0;
    logic fast_matrix_force = '0, slow_cell_request = '0, fast_cell_request = '0, comparator_request = '0;
    logic general_pin_zero = '0, general_pin_one = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, low_frequency_source, ring_source, slow_osc_run, fast_osc_run, slow_osc_rate_select;
    logic matrix_input_46, matrix_input_47, matrix_input_48;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0, taps;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          errors = 0, num_checks = 0, ratio[8] = '{1, 2, 3, 4, 8, 12, 24, 64};
    // row: por trim force cell comparator always_on polarity ext, slow run, fast run
    logic [9:0]  rows[10]='{10'h1F8, 10'h254, 10'h2D0, 10'h28B, 10'h208, 10'h213, 10'h243, 10'h222, 10'h200, 10'h387};
    assign taps = {matrix_input_48, matrix_input_47, matrix_input_46};
    dock_top     dut_u (.*);
    dock_partner par_u (.*);
    initial forever #12.5 aclk = ~aclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask
    // ====
    // bus master: hold each channel until its ready; wr raises bready, rd raises rready, and nothing lowers them, so they stay up
    task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // period of a tap, skipping the first cycle after a ratio change
    task automatic per(input int i, input int e);
        int k, n;
        logic p;
        k = 0;
        n = 0;
        p = taps[i];
        while (k < 3) begin
            @(posedge aclk);
            if (taps[i] && !p) k++;
            if (k == 2) n++;
            p = taps[i];
        end
        chk("tap_period", e, n);
    endtask
    task automatic wait_run(output int n);
        n = 0;
        while (fast_osc_run !== 1'h1) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        finish_test();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [9:0] w;
        int n0, n1;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            w = rows[i];
            wr(OFS_SLOW, {29'h0, w[2], w[3], w[4]}, r);
            wr(OFS_FAST, {29'h0, w[2], w[3], w[4]}, r);
            power_on_ok <= w[9];
            trim_enable <= w[8];
            slow_matrix_force <= w[7];
            fast_matrix_force <= w[7];
            slow_cell_request <= w[6];
            fast_cell_request <= w[6];
            comparator_request <= w[5];
            repeat (12) @(posedge aclk);
            chk("slow_run", w[1], slow_osc_run);
            chk("fast_run", w[0], fast_osc_run);
            chk("gated_taps", 32'h0, taps);
        end
        trim_enable <= 1'h0;
        slow_matrix_force <= 1'h0;
        fast_matrix_force <= 1'h0;
        // source period 8, slow first stage by two, fast first stage by twelve
        for (int c = 0; c < 8; c++) begin
            wr(OFS_SLOW, 32'h211 | (32'(c) << 6), r);
            per(0, 16 * ratio[c]);
        end
        wr(OFS_FAST, 32'h149, r);
        per(2, 384);
        wr(OFS_FAST, 32'h1C9, r);
        per(2, 288);
        wr(OFS_FAST, 32'hFFFF_FFFF, r);
        rd(OFS_FAST, d, r);
        chk("fast_cfg", 32'h7CF, d);
        wr(OFS_SLOW, 32'hFFFF_FFFF, r);
        rd(OFS_SLOW, d, r);
        chk("slow_cfg", 32'h3FFF, d);
        chk("rate_select", 32'h1, slow_osc_rate_select);
        rd(32'h10, d, r);
        chk("unmapped_rresp", RESP_SLVERR, r);
        chk("unmapped_rdata", 32'h0, d);
        wr(32'h10, 32'h0, r);
        chk("unmapped_bresp", RESP_SLVERR, r);
        // start latency with and without the startup delay
        wr(OFS_FAST, 32'h0, r);
        repeat (4) @(posedge aclk);
        wr(OFS_FAST, 32'h1, r);
        wait_run(n0);
        wr(OFS_FAST, 32'h0, r);
        repeat (4) @(posedge aclk);
        wr(OFS_FAST, 32'h401, r);
        wait_run(n1);
        chk("startup_delay", STARTUP_DLY_NS / CLK_PERIOD_NS, n1 - n0);
        finish_test();
    end
endmodule
bind dock_top dock_assertions chk_u (.*);
